// [common/pic_defines.vh]
// Constants for the prioritized interrupt controller: vectors, bit positions, widths.
// Assumes inclusion by bare name from design files.
`ifndef PIC_DEFINES_VH
`define PIC_DEFINES_VH

`define PIC_NUM_SRC        16
`define PIC_IDX_W          4
`define PIC_VEC_W          8
`define PIC_VEC_PFI        8'h33
`define PIC_VEC_EXT0       8'h03
`define PIC_VEC_TMR0       8'h0B
`define PIC_VEC_EXT1       8'h13
`define PIC_VEC_TMR1       8'h1B
`define PIC_VEC_SER0       8'h23
`define PIC_VEC_TMR2       8'h2B
`define PIC_VEC_ACT        8'h3B
`define PIC_VEC_TW1        8'h43
`define PIC_VEC_ADC        8'h4B
`define PIC_VEC_TW2        8'h53
`define PIC_VEC_KBB        8'h5B
`define PIC_VEC_PB1        8'h63
`define PIC_VEC_KEY        8'h6B
`define PIC_VEC_WDP        8'h73
`define PIC_VEC_PB2        8'h7B
`define PIC_WDC_PF_FLAG    4
`define PIC_WDC_PF_EN      5
`define PIC_WDC_WDP_FLAG   3
`define PIC_EIE_WDP        6
`define PIC_LVL_NONE       2'h0
`define PIC_LVL_LOW        2'h1
`define PIC_LVL_HIGH       2'h2
`define PIC_LVL_PF         2'h3

`endif

// [design/pic_vector_rom.v]
// Maps a natural-order index to its fixed vector address, registered.
// Assumes one clock, synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "pic_defines.vh"

module pic_vector_rom (
  input  wire                   clk,
  input  wire                   rst,
  input  wire [`PIC_IDX_W-1:0]  index,
  output reg  [`PIC_VEC_W-1:0]  vector
);
  reg [`PIC_VEC_W-1:0] vector_next;

  always @* begin
    case (index)
      4'h0:    vector_next = `PIC_VEC_PFI;
      4'h1:    vector_next = `PIC_VEC_EXT0;
      4'h2:    vector_next = `PIC_VEC_TMR0;
      4'h3:    vector_next = `PIC_VEC_EXT1;
      4'h4:    vector_next = `PIC_VEC_TMR1;
      4'h5:    vector_next = `PIC_VEC_SER0;
      4'h6:    vector_next = `PIC_VEC_TMR2;
      4'h7:    vector_next = `PIC_VEC_ACT;
      4'h8:    vector_next = `PIC_VEC_TW1;
      4'h9:    vector_next = `PIC_VEC_ADC;
      4'hA:    vector_next = `PIC_VEC_TW2;
      4'hB:    vector_next = `PIC_VEC_KBB;
      4'hC:    vector_next = `PIC_VEC_PB1;
      4'hD:    vector_next = `PIC_VEC_KEY;
      4'hE:    vector_next = `PIC_VEC_WDP;
      default: vector_next = `PIC_VEC_PB2;
    endcase
  end

  always @(posedge clk) begin
    if (rst)
      vector <= 8'h00;
    else
      vector <= vector_next;
  end
endmodule // pic_vector_rom

`default_nettype wire

// [design/pic_find_first.v]
// Finds the lowest set bit of a request vector (natural order tie break).
// Pure combinational; used once each for the high and low levels (power-fail needs no search).
`timescale 1ns/1ps
`default_nettype none
`include "pic_defines.vh"

module pic_find_first #(
  parameter N = `PIC_NUM_SRC
) (
  input  wire [N-1:0]           req,
  output reg                    found,
  output reg  [`PIC_IDX_W-1:0]  index
);
  integer i;

  // Scan from the top down so the lowest index is the last written
  always @* begin
    found = 1'b0;
    index = {`PIC_IDX_W{1'b0}};
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (req[i]) begin
        found = 1'b1;
        index = i[`PIC_IDX_W-1:0];
      end
    end
  end
endmodule // pic_find_first

`default_nettype wire

// [design/pic_controller.v]
// Prioritized interrupt controller: 16 sources, three levels, fixed vectors.
// Assumes all inputs synchronous to clk; the core acknowledges each request.
`timescale 1ns/1ps
`default_nettype none
`include "pic_defines.vh"

module pic_controller (
  input  wire        clk,
  input  wire        rst,
  input  wire [7:0]  watchdog_control_reg,
  input  wire [7:0]  basic_enable_reg,
  input  wire [7:0]  basic_priority_reg,
  input  wire [7:0]  extended_enable_reg,
  input  wire [7:0]  extended_priority_reg,
  input  wire        external_request_zero,
  input  wire        timer_zero_overflow,
  input  wire        external_request_one,
  input  wire        timer_one_overflow,
  input  wire        serial_transmit_done,
  input  wire        serial_receive_done,
  input  wire        timer_two_flag,
  input  wire [7:0]  activity_flags,
  input  wire        two_wire_first_request,
  input  wire        conversion_done_request,
  input  wire        two_wire_second_request,
  input  wire        keyboard_buffer_request,
  input  wire        power_buffer_first_request,
  input  wire [7:0]  key_detect_flags,
  input  wire        power_buffer_second_request,
  input  wire        vector_ack,
  input  wire        return_done,
  output reg         irq_valid,
  output wire [7:0]  irq_vector,
  output reg  [3:0]  irq_index,
  output reg  [1:0]  irq_level,
  output reg  [1:0]  active_level
);
  // Decoded request and control bits
  wire        power_fail_request;
  wire        power_fail_enable;
  wire        watchdog_periodic_request;
  wire        activity_monitor_request;
  wire        key_detect_request;
  wire [15:0] pend;
  wire [15:0] enable;
  wire [15:0] prio_high;
  wire [15:0] req;
  wire [15:0] req_high;
  wire [15:0] req_low;
  wire        hi_found;
  wire        lo_found;
  wire [3:0]  hi_index;
  wire [3:0]  lo_index;
  reg         win_found;
  reg  [3:0]  win_index;
  reg  [1:0]  win_level;
  reg         irq_valid_next;
  reg  [1:0]  active_level_next;
  // Two saved levels: low, then high, then power-fail may all be in service
  reg  [3:0]  stack_reg;
  reg  [3:0]  stack_next;

  assign power_fail_request        = watchdog_control_reg[`PIC_WDC_PF_FLAG];
  assign power_fail_enable         = watchdog_control_reg[`PIC_WDC_PF_EN];
  assign watchdog_periodic_request = watchdog_control_reg[`PIC_WDC_WDP_FLAG];
  assign activity_monitor_request  = |activity_flags;
  assign key_detect_request        = |key_detect_flags;

  // Natural order: index 0 is order 1
  assign pend = {power_buffer_second_request, watchdog_periodic_request,
                 key_detect_request, power_buffer_first_request,
                 keyboard_buffer_request, two_wire_second_request,
                 conversion_done_request, two_wire_first_request,
                 activity_monitor_request, timer_two_flag,
                 serial_transmit_done | serial_receive_done,
                 timer_one_overflow, external_request_one,
                 timer_zero_overflow, external_request_zero,
                 power_fail_request};

  assign enable    = {extended_enable_reg, basic_enable_reg[6:0], power_fail_enable};
  // Power-fail has no priority bit; it is never part of the user levels
  assign prio_high = {extended_priority_reg, basic_priority_reg[6:0], 1'b0};
  assign req       = pend & enable;
  assign req_high  = {req[15:1] & prio_high[15:1], 1'b0};
  assign req_low   = {req[15:1] & ~prio_high[15:1], 1'b0};

  pic_find_first #(
    .N (`PIC_NUM_SRC)
  ) u_find_high (
    .req   (req_high),
    .found (hi_found),
    .index (hi_index)
  );

  pic_find_first #(
    .N (`PIC_NUM_SRC)
  ) u_find_low (
    .req   (req_low),
    .found (lo_found),
    .index (lo_index)
  );

  // Level resolution: power-fail, then high, then low
  always @* begin
    if (req[0]) begin
      win_found = 1'b1;
      win_index = 4'h0;
      win_level = `PIC_LVL_PF;
    end else if (hi_found) begin
      win_found = 1'b1;
      win_index = hi_index;
      win_level = `PIC_LVL_HIGH;
    end else if (lo_found) begin
      win_found = 1'b1;
      win_index = lo_index;
      win_level = `PIC_LVL_LOW;
    end else begin
      win_found = 1'b0;
      win_index = 4'h0;
      win_level = `PIC_LVL_NONE;
    end
  end

  // A request is offered only if it outranks the level in service.
  // Offer is held stable one cycle later than the winner (vector is registered).
  always @* begin
    irq_valid_next    = win_found && (win_level > active_level) && !vector_ack;
    active_level_next = active_level;
    stack_next        = stack_reg;
    if (irq_valid && vector_ack) begin
      stack_next        = {stack_reg[1:0], active_level};
      active_level_next = irq_level;
    end else if (return_done) begin
      // Pop the newest saved level; the older one moves down
      active_level_next = stack_reg[1:0];
      stack_next        = {`PIC_LVL_NONE, stack_reg[3:2]};
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      irq_valid    <= 1'b0;
      irq_index    <= 4'h0;
      irq_level    <= `PIC_LVL_NONE;
      active_level <= `PIC_LVL_NONE;
      stack_reg    <= {2{`PIC_LVL_NONE}};
    end else begin
      irq_valid    <= irq_valid_next;
      irq_index    <= win_index;
      irq_level    <= win_level;
      active_level <= active_level_next;
      stack_reg    <= stack_next;
    end
  end

  pic_vector_rom u_rom (
    .clk    (clk),
    .rst    (rst),
    .index  (win_index),
    .vector (irq_vector)
  );
endmodule // pic_controller

`default_nettype wire

// [tb/pic_controller_assertions.sv]
// Port checker for the interrupt controller.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module pic_checker (
  input wire       clk,
  input wire       rst,
  input wire [7:0] watchdog_control_reg,
  input wire [7:0] basic_enable_reg,
  input wire [7:0] extended_enable_reg,
  input wire       vector_ack,
  input wire       return_done,
  input wire       irq_valid,
  input wire [7:0] irq_vector,
  input wire [3:0] irq_index,
  input wire [1:0] irq_level,
  input wire [1:0] active_level
);
  // Vector table is not linear: power-fail sits between orders 7 and 8
  wire [7:0] vx = (irq_index == 4'h0) ? 8'h33 : (irq_index < 4'h7) ?
    {1'b0, irq_index - 4'h1, 3'h3} : {1'b0, irq_index, 3'h3};
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_ack_clear: assert property (vector_ack && irq_valid |=> !irq_valid)
    else $error("offer stayed after ack");
  chk_ack_level: assert property (vector_ack && irq_valid |=>
    active_level == $past(irq_level)) else $error("level not taken");
  chk_pf_wins: assert property (watchdog_control_reg[5:4] == 2'h3 &&
    active_level == 2'h0 && !vector_ack && !return_done |=>
    irq_valid && irq_vector == 8'h33 && irq_level == 2'h3) else $error("pf lost");
  chk_no_low: assert property (irq_valid |-> irq_level > active_level)
    else $error("offer not above service level");
  chk_vec_map: assert property (irq_valid |-> irq_vector == vx)
    else $error("vector does not match order");
  chk_pf_code: assert property (irq_valid |->
    (irq_level == 2'h3) == (irq_index == 4'h0)) else $error("pf level code");
  chk_reset_idle: assert property (disable iff (1'b0) rst |=>
    !irq_valid && active_level == 2'h0) else $error("not idle after reset");
  chk_ret_drop: assert property (return_done && !vector_ack &&
    active_level != 2'h0 |=> active_level < $past(active_level))
    else $error("return kept level");
  chk_mask_off: assert property (!watchdog_control_reg[5] &&
    basic_enable_reg[6:0] == 7'h00 && extended_enable_reg == 8'h00 |=> !irq_valid)
    else $error("masked offer");
  cover property (vector_ack && irq_valid);
  cover property (irq_valid && irq_level == 2'h3);
  cover property (return_done && active_level != 2'h0);
endmodule // pic_checker
bind pic_controller pic_checker i_pic_checker (.clk(clk), .rst(rst),
  .watchdog_control_reg(watchdog_control_reg), .basic_enable_reg(basic_enable_reg),
  .extended_enable_reg(extended_enable_reg), .vector_ack(vector_ack),
  .return_done(return_done), .irq_valid(irq_valid), .irq_vector(irq_vector),
  .irq_index(irq_index), .irq_level(irq_level), .active_level(active_level));
`default_nettype wire

// [tb/pic_core_model.sv]
// Core side: acknowledges offers when allowed, pulses handler returns.
// Assumes the bench gates acks with take, so slow answers are possible.
`timescale 1ns/1ps
`default_nettype none
module pic_core_model (
  input  wire  clk,
  input  wire  rst,
  input  wire  irq_valid,
  input  wire  take,
  input  wire  ret_req,
  output logic vector_ack,
  output logic return_done
);
  // Pulses only; a held ack would be read as a second fetch
  always @(posedge clk) begin
    vector_ack <= !rst && take && irq_valid && !vector_ack;
    return_done <= !rst && ret_req && !return_done;
  end
endmodule // pic_core_model
`default_nettype wire

// [tb/tb_pic_controller.sv]
// Bench for the interrupt controller with a core model.
// Assumes 25 MHz clock and a two-cycle reset.
`timescale 1ns/1ps
`default_nettype none
module tb_pic_controller;
  logic clk = 0, rst = 1, rx = 0, pfen = 1, take = 0, ret = 0;
  logic [15:0] src = 0;
  logic [7:0] ben = 8'h7F, bpr = 0, een = 8'hFF, epr = 0, irq_vector;
  logic irq_valid, vector_ack, return_done;
  logic [3:0] irq_index;
  logic [1:0] irq_level, active_level;
  int mismatches = 0, num_checks = 0, i, n;
  initial forever #20 clk = ~clk;
  pic_core_model i_pic_core_model (.clk(clk), .rst(rst), .irq_valid(irq_valid),
    .take(take), .ret_req(ret), .vector_ack(vector_ack), .return_done(return_done));
  pic_controller i_pic_controller (.clk(clk), .rst(rst),
    .watchdog_control_reg({2'h0, pfen, src[0], src[14], 3'h0}),
    .basic_enable_reg(ben), .basic_priority_reg(bpr), .extended_enable_reg(een),
    .extended_priority_reg(epr), .external_request_zero(src[1]),
    .timer_zero_overflow(src[2]), .external_request_one(src[3]),
    .timer_one_overflow(src[4]), .serial_transmit_done(src[5]),
    .serial_receive_done(rx), .timer_two_flag(src[6]),
    .activity_flags({src[7], 7'h00}), .two_wire_first_request(src[8]),
    .conversion_done_request(src[9]), .two_wire_second_request(src[10]),
    .keyboard_buffer_request(src[11]), .power_buffer_first_request(src[12]),
    .key_detect_flags({7'h00, src[13]}), .power_buffer_second_request(src[15]),
    .vector_ack(vector_ack), .return_done(return_done), .irq_valid(irq_valid),
    .irq_vector(irq_vector), .irq_index(irq_index), .irq_level(irq_level),
    .active_level(active_level));
  task results;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task ck(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  function automatic [7:0] ev(input int k);
    ev = (k == 0) ? 8'h33 : (k < 7) ? 8'(8 * k - 5) : 8'(8 * k + 3);
  endfunction
  // Level 0 means nothing may be offered
  task go(input [15:0] s, input [7:0] v, input [1:0] l);
    @(posedge clk) src <= s;
    repeat (2) @(posedge clk);
    #1;
    ck(irq_valid === (l != 2'h0) && (l == 2'h0 || irq_vector === v &&
      irq_level === l), "offer");
  endtask
  task wack(input [1:0] l);
    @(posedge clk) take <= 1;
    for (n = 0; n < 20 && vector_ack !== 1'b1; n++) @(posedge clk);
    take <= 0;
    if (n == 20) begin
      ck(0, "no ack");
      results;
    end
    #1;
    ck(active_level === l && irq_valid === 1'b0, "service level");
  endtask
  task rdone(input [1:0] l);
    @(posedge clk) ret <= 1;
    @(posedge clk) ret <= 0;
    @(posedge clk) #1;
    ck(active_level === l, "return level");
  endtask
  task t_vec;
    for (i = 0; i < 16; i++) begin
      go(16'h1 << i, ev(i), i == 0 ? 2'h3 : 2'h1);
      ck(irq_index === 4'(i), "index");
    end
    @(posedge clk) rx <= 1;
    go(16'h0, 8'h23, 2'h1);
    @(posedge clk) rx <= 0;
    $display("test vectors done");
  endtask
  task t_prio;
    go(16'hFFFE, 8'h03, 2'h1);
    @(posedge clk) bpr <= 8'h40;
    go(16'hFFFE, 8'h3B, 2'h2);
    @(posedge clk) begin bpr <= 0; epr <= 8'h40; end
    go(16'hFFFE, 8'h73, 2'h2);
    go(16'hFFFF, 8'h33, 2'h3);
    @(posedge clk) pfen <= 0;
    go(16'hFFFF, 8'h73, 2'h2);
    @(posedge clk) begin ben <= 0; een <= 0; end
    go(16'hFFFF, 8'h00, 2'h0);
    @(posedge clk) ben <= 8'h20;
    go(16'hFFFF, 8'h2B, 2'h1);
    @(posedge clk) begin ben <= 0; een <= 8'h40; epr <= 0; end
    go(16'hFFFF, 8'h73, 2'h1);
    $display("test priority done");
  endtask
  task t_nest;
    @(posedge clk) begin ben <= 8'h7F; een <= 8'hFF; pfen <= 1; end
    go(16'h0004, 8'h0B, 2'h1);
    wack(2'h1);
    go(16'h0006, 8'h00, 2'h0);
    go(16'h0007, 8'h33, 2'h3);
    wack(2'h3);
    rdone(2'h1);
    @(posedge clk) src <= 0;
    rdone(2'h0);
    $display("test nesting done");
  endtask
  // Reset in mid-run must drop a level that is in service
  task t_rst;
    go(16'h0001, 8'h33, 2'h3);
    wack(2'h3);
    @(posedge clk) rst <= 1;
    @(posedge clk) rst <= 0;
    #1;
    ck(active_level === 2'h0 && irq_valid === 1'b0, "reset level");
    $display("test reset done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    t_vec;
    t_prio;
    t_nest;
    t_rst;
    results;
  end
endmodule // tb_pic_controller
`default_nettype wire
